// ### mct_pkg.sv
// Purpose: constants and types of the counter/timer channel
// Assumes: 50 MHz system clock, 20 MHz internal time base
// Notes: offsets, encodings and timing figures live here only
package mct_pkg;
	localparam int SYS_CLK_MHZ = 50;
	localparam int TIMEBASE_MHZ = 20;
	localparam int ACC_W = 7;
	localparam logic [ACC_W-1:0] TB_STEP = ACC_W'(TIMEBASE_MHZ);
	localparam logic [ACC_W-1:0] TB_MOD = ACC_W'(SYS_CLK_MHZ);
	localparam logic [6:0] DUTY_FULL = 7'h64;
	localparam logic [23:0] DUTY_DIV = 24'h000064;
	localparam logic OUT_HI_LO = 1'h0;
	localparam logic SRC_INT = 1'h0;
	// Gray along idle, armed, pulse, done
	typedef enum logic [1:0] {
		MCT_IDLE = 2'h0,
		MCT_ARMED = 2'h1,
		MCT_PULSE = 2'h3,
		MCT_DONE = 2'h2
	} mct_state_t;
	typedef enum logic [2:0] {
		MCT_EVENT = 3'h0,
		MCT_FREQ = 3'h1,
		MCT_RATE = 3'h3,
		MCT_ONESHOT = 3'h2,
		MCT_REPEAT = 3'h6
	} mct_mode_t;
	typedef enum logic [2:0] {
		MCT_GATE_NONE = 3'h0,
		MCT_GATE_LOW = 3'h1,
		MCT_GATE_HIGH = 3'h2,
		MCT_GATE_FALL = 3'h3,
		MCT_GATE_RISE = 3'h4
	} mct_gate_t;
	// Divider field of zero means the full 65,536
	function automatic logic [16:0] mct_div_full(input logic [15:0] d);
		mct_div_full = (d == 16'h0000) ? 17'h10000 : {1'h0, d};
	endfunction
	// Active ticks per period, at least one when duty is nonzero
	function automatic logic [16:0] mct_thr(input logic [16:0] dv, input logic [6:0] duty);
		logic [23:0] prod;
		prod = 24'(dv) * 24'(duty);
		if (duty >= DUTY_FULL)
			mct_thr = dv;
		else if (duty == 7'h00)
			mct_thr = 17'h00000;
		else if (prod < DUTY_DIV)
			mct_thr = 17'h00001;
		else
			mct_thr = 17'(prod / DUTY_DIV);
	endfunction
endpackage

// ### mct_timer.sv
// Purpose: one user counter/timer channel with a 32-bit cascade
// Assumes: config held steady while enable is high
// Notes: pins pass three flops; the count reads after stop
`timescale 1ns/1ns
module mct_timer
	import mct_pkg::*;
#(
	parameter int CNT_W = 16
)
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic enable,
	input wire mct_mode_t mode,
	input wire mct_gate_t gate_type,
	input wire logic clk_src,
	input wire logic cascade_en,
	input wire logic out_type,
	input wire logic [6:0] duty,
	input wire logic [15:0] divider,
	input wire logic ext_clk_in,
	input wire logic gate_in,
	output logic pulse_out,
	output logic [2*CNT_W-1:0] count_out,
	output logic running,
	output logic done
);

	// Refuse widths the divider and count paths cannot serve
	if (CNT_W < 2 || CNT_W > 16)
	begin : g_chk_w
		$error("CNT_W must lie in 2..16");
	end
	if (2 * TIMEBASE_MHZ > SYS_CLK_MHZ)
	begin : g_chk_tb
		$error("time base too fast for system clock");
	end

	typedef struct packed {
		mct_state_t st;
		logic [2:0] clk_sync;
		logic [2:0] gate_sync;
		logic clk_lvl;
		logic gate_lvl;
		logic [ACC_W-1:0] acc;
		logic [CNT_W-1:0] lo;
		logic [CNT_W-1:0] hi;
		logic [15:0] phase;
		logic pulse;
		logic running;
		logic done;
	} mct_reg_t;

	mct_reg_t state_ff;
	mct_reg_t nxt_state;
	logic [ACC_W-1:0] acc_sum;
	logic int_tick;
	logic ext_rise;
	logic gate_rise;
	logic gate_fall;
	logic tick;
	logic gate_act;
	logic trig;
	logic act_lvl;
	logic [16:0] div_full;
	logic [16:0] last_ph;
	logic [16:0] thr;
	logic [16:0] ph_next;
	logic rate_run;
	logic pulse_mode;

	// Next-state logic for the whole channel
	always_comb
	begin
		nxt_state = state_ff;
		acc_sum = state_ff.acc + TB_STEP;
		int_tick = 1'h0;
		ext_rise = 1'h0;
		gate_rise = 1'h0;
		gate_fall = 1'h0;
		tick = 1'h0;
		gate_act = 1'h0;
		trig = 1'h0;
		rate_run = 1'h0;
		ph_next = {1'h0, state_ff.phase} + 17'h00001;
		div_full = mct_div_full(divider);
		last_ph = div_full - 17'h00001;
		pulse_mode = (mode == MCT_ONESHOT) || (mode == MCT_REPEAT);
		// One-shot modes ignore the duty setting: full width
		thr = pulse_mode ? div_full : mct_thr(div_full, duty);
		// Low-to-high drives high when active, else low
		act_lvl = (out_type != OUT_HI_LO);

		// Stage zero only feeds stage one; level moves when 1 and 2 agree
		nxt_state.clk_sync = {state_ff.clk_sync[1:0], ext_clk_in};
		nxt_state.gate_sync = {state_ff.gate_sync[1:0], gate_in};
		if (state_ff.clk_sync[1] == state_ff.clk_sync[2])
			nxt_state.clk_lvl = state_ff.clk_sync[1];
		if (state_ff.gate_sync[1] == state_ff.gate_sync[2])
			nxt_state.gate_lvl = state_ff.gate_sync[1];
		ext_rise = nxt_state.clk_lvl & ~state_ff.clk_lvl;
		gate_rise = nxt_state.gate_lvl & ~state_ff.gate_lvl;
		gate_fall = ~nxt_state.gate_lvl & state_ff.gate_lvl;

		// Fractional accumulator: 20 ticks in every 50 system cycles
		if (acc_sum >= TB_MOD)
		begin
			int_tick = 1'h1;
			nxt_state.acc = acc_sum - TB_MOD;
		end
		else
			nxt_state.acc = acc_sum;
		tick = (clk_src == SRC_INT) ? int_tick : ext_rise;

		// Level gates enable; edge types are not gating, so pass
		case (gate_type)
			MCT_GATE_LOW: gate_act = ~state_ff.gate_lvl;
			MCT_GATE_HIGH: gate_act = state_ff.gate_lvl;
			default: gate_act = 1'h1;
		endcase
		// Triggers for the one-shot modes
		case (gate_type)
			MCT_GATE_FALL: trig = gate_fall;
			MCT_GATE_RISE: trig = gate_rise;
			MCT_GATE_LOW: trig = ~state_ff.gate_lvl;
			MCT_GATE_HIGH: trig = state_ff.gate_lvl;
			default: trig = 1'h1;
		endcase

		case (state_ff.st)
			MCT_IDLE:
			begin
				nxt_state.pulse = ~act_lvl;
				if (enable)
				begin
					nxt_state.st = MCT_ARMED;
					nxt_state.lo = '0;
					nxt_state.hi = '0;
					nxt_state.phase = 16'h0000;
					nxt_state.running = 1'h1;
					nxt_state.done = 1'h0;
				end
			end
			MCT_ARMED:
			begin
				if (!enable)
				begin
					// Output drops to idle at once on disable
					nxt_state.st = MCT_IDLE;
					nxt_state.running = 1'h0;
					nxt_state.pulse = ~act_lvl;
				end
				else
				begin
					case (mode)
						MCT_EVENT, MCT_FREQ:
						begin
							// Frequency mode counts only in the gate window
							if (tick && gate_act)
							begin
								// Natural wrap of the low half
								nxt_state.lo = state_ff.lo + CNT_W'(1);
								// Low carry is the upper half's clock
								if (cascade_en && (&state_ff.lo))
									nxt_state.hi = state_ff.hi + CNT_W'(1);
							end
						end
						MCT_RATE:
						begin
							if (gate_act)
							begin
								rate_run = 1'h1;
								// Period spans divider clock ticks
								if (tick)
								begin
									if ({1'h0, state_ff.phase} >= last_ph)
										nxt_state.phase = 16'h0000;
									else
										nxt_state.phase = ph_next[15:0];
								end
								// Active while the phase is below the threshold
								if ({1'h0, nxt_state.phase} < thr)
									nxt_state.pulse = act_lvl;
								else
									nxt_state.pulse = ~act_lvl;
							end
							else
								nxt_state.pulse = ~act_lvl;
						end
						MCT_ONESHOT, MCT_REPEAT:
						begin
							nxt_state.pulse = ~act_lvl;
							if (trig)
							begin
								nxt_state.st = MCT_PULSE;
								nxt_state.phase = 16'h0000;
								nxt_state.pulse = act_lvl;
							end
						end
						default:
							nxt_state.pulse = ~act_lvl;
					endcase
				end
			end
			MCT_PULSE:
			begin
				// Gate is not watched here, so retriggers are lost
				if (!enable)
				begin
					nxt_state.st = MCT_IDLE;
					nxt_state.running = 1'h0;
					nxt_state.pulse = ~act_lvl;
				end
				else if (tick)
				begin
					if ({1'h0, state_ff.phase} >= last_ph)
					begin
						nxt_state.phase = 16'h0000;
						nxt_state.pulse = ~act_lvl;
						if (mode == MCT_REPEAT)
							nxt_state.st = MCT_ARMED;
						else
						begin
							nxt_state.st = MCT_DONE;
							nxt_state.running = 1'h0;
							nxt_state.done = 1'h1;
						end
					end
					else
						nxt_state.phase = ph_next[15:0];
				end
			end
			MCT_DONE:
			begin
				// Clock and gate ignored until software stops it
				nxt_state.pulse = ~act_lvl;
				if (!enable)
					nxt_state.st = MCT_IDLE;
			end
			default:
			begin
				nxt_state.st = MCT_IDLE;
				nxt_state.running = 1'h0;
			end
		endcase
	end

	// Single state register; reset takes a constant only
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			state_ff <= '0;
		else
			state_ff <= nxt_state;
	end

	// Outputs straight from the state flops
	assign pulse_out = state_ff.pulse;
	assign count_out = {state_ff.hi, state_ff.lo};
	assign running = state_ff.running;
	assign done = state_ff.done;

	// Low half wraps to zero on its 65,536th event
	property p_wrap_lo;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_ff.st == MCT_ARMED) && enable && (mode == MCT_EVENT) && tick && gate_act
			&& (&state_ff.lo) |=> (state_ff.lo == '0);
	endproperty
	a_wrap_lo: assert property (p_wrap_lo) else $error("low count did not wrap");

	// With cascade on, the upper half steps on every low-half carry
	property p_casc;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_ff.st == MCT_ARMED) && enable && cascade_en && (mode == MCT_EVENT)
			&& tick && gate_act && (&state_ff.lo)
			|=> (state_ff.hi == $past(state_ff.hi) + CNT_W'(1)) && (state_ff.lo == '0);
	endproperty
	a_casc: assert property (p_casc) else $error("cascade carry lost");

	// No counting while the gate is inactive
	property p_gate_hold;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_ff.st == MCT_ARMED) && enable && (mode == MCT_FREQ) && !gate_act
			|=> $stable(state_ff.lo) && $stable(state_ff.hi);
	endproperty
	a_gate_hold: assert property (p_gate_hold) else $error("count moved with gate off");

	// Disable idles the output on the next edge
	property p_stop;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_ff.st == MCT_ARMED) && !enable
			|=> (state_ff.st == MCT_IDLE) && (pulse_out == ~act_lvl) && !running;
	endproperty
	a_stop: assert property (p_stop) else $error("rate output did not stop");

	// Rate output follows phase against threshold
	property p_duty;
		@(posedge clk_sys) disable iff (!reset_n)
		rate_run && $stable(duty) && $stable(divider) && $stable(out_type)
			|=> pulse_out == (({1'h0, state_ff.phase} < thr) ? act_lvl : ~act_lvl);
	endproperty
	a_duty: assert property (p_duty) else $error("duty compare wrong");

	// Once done, the state holds while enabled
	property p_once;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_ff.st == MCT_DONE) && enable |=> (state_ff.st == MCT_DONE) && done
			&& (pulse_out == ~$past(act_lvl));
	endproperty
	a_once: assert property (p_once) else $error("one-shot restarted");

	// A pulse in progress keeps its phase on a retrigger
	property p_no_retrig;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_ff.st == MCT_PULSE) && enable && trig && !tick
			|=> (state_ff.st == MCT_PULSE) && $stable(state_ff.phase);
	endproperty
	a_no_retrig: assert property (p_no_retrig) else $error("retrigger during pulse");

	// Full width: active for the whole pulse
	property p_full;
		@(posedge clk_sys) disable iff (!reset_n)
		$past(state_ff.st == MCT_PULSE) && (state_ff.st == MCT_PULSE) && $stable(out_type)
			|-> (pulse_out == act_lvl);
	endproperty
	a_full: assert property (p_full) else $error("pulse not full width");

	// Repetitive mode re-arms after each pulse
	property p_rearm;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_ff.st == MCT_PULSE) && enable && tick && (mode == MCT_REPEAT)
			&& ({1'h0, state_ff.phase} >= last_ph) |=> (state_ff.st == MCT_ARMED) && running;
	endproperty
	a_rearm: assert property (p_rearm) else $error("repeat mode did not re-arm");

	// Time base never ticks two cycles running
	property p_tb;
		@(posedge clk_sys) disable iff (!reset_n)
		int_tick |=> !int_tick;
	endproperty
	a_tb: assert property (p_tb) else $error("time base too fast");

endmodule

// ### mct_far_end.sv
// Purpose: external clock and gate wiring of the channel
// Assumes: bench calls the tasks from its main sequence
// Notes: clock pin stands low between bursts
`timescale 1ns/1ns
module mct_far_end
(
	input wire logic clk_sys,
	output logic ext_clk_in,
	output logic gate_in
);
	// Pins start low before any burst
	initial ext_clk_in = 1'h0;
	initial gate_in = 1'h0;
	// Edges four cycles apart, so the pin sync never drops one
	task automatic clks(input int n);
		repeat (n)
		begin
			repeat (4) @(negedge clk_sys);
			ext_clk_in = 1'h1;
			repeat (4) @(negedge clk_sys);
			ext_clk_in = 1'h0;
		end
	endtask
	// Gate pulse of w cycles from the standing level
	task automatic gate_pulse(input int w);
		@(negedge clk_sys);
		gate_in = ~gate_in;
		repeat (w) @(negedge clk_sys);
		gate_in = ~gate_in;
	endtask
	// Static gate level
	task automatic gate_set(input logic v);
		@(negedge clk_sys);
		gate_in = v;
	endtask
endmodule

// ### multimode_counter_timer_tb_top.sv
// Purpose: self-checking bench of the counter/timer channel
// Assumes: narrow counter so wrap points are reachable
// Notes: pins change at falling edges, outputs sampled after rising
`timescale 1ns/1ns
module multimode_counter_timer_tb_top import mct_pkg::*;;
	localparam int CW = 4;
	logic clk_sys = 1'h0;
	logic reset_n = 1'h0;
	logic enable = 1'h0;
	mct_mode_t mode;
	mct_gate_t gate_type;
	logic clk_src;
	logic cascade_en;
	logic out_type;
	logic [6:0] duty;
	logic [15:0] divider;
	logic ext_clk_in;
	logic gate_in;
	logic pulse_out;
	logic [2*CW-1:0] count_out;
	logic running;
	logic done;
	logic [31:0] seed = 32'h40ae;
	int n_mismatch = 0;
	int cmp_count = 0;
	int act_n = 0;
	int start_n = 0;
	int tb_acc = 0;
	int tick_act = 0;
	logic last_act = 1'h0;
	int a;
	// 50 MHz system clock
	always #10 clk_sys = ~clk_sys;
	mct_timer #(.CNT_W(CW)) dut_u (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.enable(enable),
		.mode(mode),
		.gate_type(gate_type),
		.clk_src(clk_src),
		.cascade_en(cascade_en),
		.out_type(out_type),
		.duty(duty),
		.divider(divider),
		.ext_clk_in(ext_clk_in),
		.gate_in(gate_in),
		.pulse_out(pulse_out),
		.count_out(count_out),
		.running(running),
		.done(done)
	);
	mct_far_end far_u (
		.clk_sys(clk_sys),
		.ext_clk_in(ext_clk_in),
		.gate_in(gate_in)
	);
	// Active samples and active starts; sampled late to dodge edge races
	// Time base model counts ticks inside active spans; cycle counts jitter, tick counts do not
	always @(posedge clk_sys)
	begin
		#2;
		if (!reset_n)
			tb_acc = 0;
		else
		begin
			tb_acc += TIMEBASE_MHZ;
			if (tb_acc >= SYS_CLK_MHZ)
			begin
				tb_acc -= SYS_CLK_MHZ;
				if (last_act)
					tick_act++;
			end
		end
		if (pulse_out === out_type)
			act_n++;
		if (pulse_out === out_type && !last_act)
			start_n++;
		last_act = (pulse_out === out_type);
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Count after n edges wraps at the counter width
	function automatic logic [31:0] exp_cnt(input int n, input logic c);
		return c ? n % (1 << (2 * CW)) : n % (1 << CW);
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Stop, then reconfigure; config never moves while enabled
	task automatic run(input mct_mode_t m, input mct_gate_t g, input logic src, input logic casc,
		input logic ot, input logic [6:0] dt, input logic [15:0] dv);
		@(negedge clk_sys);
		enable = 1'h0;
		repeat (2) @(negedge clk_sys);
		mode = m;
		gate_type = g;
		clk_src = src;
		cascade_en = casc;
		out_type = ot;
		duty = dt;
		divider = dv;
		repeat (8) @(negedge clk_sys);
		enable = 1'h1;
		repeat (2) @(negedge clk_sys);
	endtask
	// Align to the start of an active portion
	task automatic wait_start;
		start_n = 0;
		for (int k = 0; k < 300 && start_n == 0; k++)
			@(negedge clk_sys);
		act_n = 1;
		start_n = 0;
	endtask
	// Main sequence
	initial
	begin
		// Random setup while stopped; nothing runs until enable rises
		seed = lfsr(seed);
		mode = MCT_EVENT;
		gate_type = MCT_GATE_NONE;
		{cascade_en, clk_src, out_type, duty, divider} = seed[25:0];
		repeat (16) @(negedge clk_sys);
		reset_n = 1'h1;
		// Ungated counts past the wrap, single and cascaded
		for (int i = 0; i < 4; i++)
		begin
			seed = lfsr(seed);
			a = (i == 3) ? 257 : seed % 40;
			run(MCT_EVENT, MCT_GATE_NONE, 1'h1, i[0], 1'h1, 7'h32, 16'h0014);
			far_u.clks(a);
			repeat (8) @(negedge clk_sys);
			chk("count", count_out, exp_cnt(a, i[0]));
		end
		// Level gates; edges outside the gate must not count
		for (int i = 0; i < 4; i++)
		begin
			seed = lfsr(seed);
			a = seed % 20 + 1;
			far_u.gate_set(~i[0]);
			run(i[1] ? MCT_FREQ : MCT_EVENT, i[0] ? MCT_GATE_HIGH : MCT_GATE_LOW, 1'h1, 1'h0, 1'h1, 7'h32,
				16'h0014);
			far_u.clks(3);
			far_u.gate_set(i[0]);
			far_u.clks(a);
			far_u.gate_set(~i[0]);
			far_u.clks(3);
			repeat (8) @(negedge clk_sys);
			chk("gated count", count_out, exp_cnt(a, 1'h0));
		end
		// Rate generation; divider 20 gives a 50-cycle period
		for (int i = 0; i < 6; i++)
		begin
			seed = lfsr(seed);
			a = (seed % 9 + 1) * 10;
			run(MCT_RATE, MCT_GATE_NONE, 1'h0, 1'h0, seed[4], 7'(a), i == 5 ? 16'h0002 : 16'h0014);
			repeat (60) @(negedge clk_sys);
			wait_start();
			repeat (i == 5 ? 9 : 99) @(negedge clk_sys);
			chk("starts", start_n, 1);
			if (i < 5)
				chk("active", act_n, a);
		end
		enable = 1'h0;
		repeat (2) @(negedge clk_sys);
		act_n = 0;
		repeat (60) @(negedge clk_sys);
		chk("stopped", act_n, 0);
		// One-shot on either edge; the second trigger is ignored
		for (int i = 0; i < 2; i++)
		begin
			seed = lfsr(seed);
			far_u.gate_set(i[0]);
			run(MCT_ONESHOT, i[0] ? MCT_GATE_FALL : MCT_GATE_RISE, 1'h0, 1'h0, seed[3], 7'h1e, 16'h0014);
			start_n = 0;
			tick_act = 0;
			far_u.gate_pulse(8);
			repeat (100) @(negedge clk_sys);
			far_u.gate_pulse(8);
			repeat (100) @(negedge clk_sys);
			chk("one pulse", tick_act, 20);
			chk("one start", start_n, 1);
			chk("done", {running, done}, 2'h1);
		end
		// Repetitive one-shot with a trigger inside the pulse
		far_u.gate_set(1'h0);
		run(MCT_REPEAT, MCT_GATE_RISE, 1'h0, 1'h0, 1'h0, 7'h1e, 16'h0014);
		tick_act = 0;
		start_n = 0;
		far_u.gate_pulse(8);
		repeat (12) @(negedge clk_sys);
		far_u.gate_pulse(8);
		repeat (60) @(negedge clk_sys);
		far_u.gate_pulse(8);
		repeat (80) @(negedge clk_sys);
		chk("pulses", start_n, 2);
		chk("width", tick_act, 40);
		chk("running", running, 1'h1);
		final_report();
	end
	// Watchdog well beyond the expected run of under 10k cycles
	initial
	begin
		repeat (40000) @(posedge clk_sys);
		n_mismatch++;
		final_report();
	end
endmodule
